//--- core/t01cm_pkg.sv
// Package: register layouts, mode codes and reset values for the timer 0/1 control block
package t01cm_pkg;

	// Timer run and flags register layout
	typedef struct packed {
		logic tf1;
		logic tr1;
		logic tf0;
		logic tr0;
		logic ie1;
		logic it1;
		logic ie0;
		logic it0;
	} t01cm_timer_run_and_flags_t;

	// Timer mode select register layout
	typedef struct packed {
		logic       timer1_gate_control;
		logic       ct1;
		logic [1:0] t1m;
		logic       timer0_gate_control;
		logic       ct0;
		logic [1:0] t0m;
	} t01cm_timer_mode_select_t;

	// Reset values
	localparam logic [7:0]  TIMER_RUN_AND_FLAGS_RST  = 8'h00;
	localparam logic [7:0]  TIMER_MODE_SELECT_RST  = 8'h00;
	localparam logic [15:0] CNT_RST   = 16'h0000;

	// Operating mode encodings
	localparam logic [1:0]  MODE_13B  = 2'h0;
	localparam logic [1:0]  MODE_16B  = 2'h1;

	// Count limits and layout of the 13-bit count
	localparam logic [12:0] CNT13_MAX = 13'h1FFF;
	localparam logic [15:0] CNT16_MAX = 16'hFFFF;
	localparam logic [12:0] CNT13_ONE = 13'h0001;
	localparam logic [15:0] CNT16_ONE = 16'h0001;
	localparam int          TL_LO_W   = 5;

endpackage

//--- core/t01cm_timer_regs.sv
// Timer 0/1 control, mode registers and 13/16-bit count logic
`timescale 1ns/1ns

module t01cm_timer_regs (
	// Clock and reset
	input  wire logic                      clk,
	input  wire logic                      nrst,
	// Special function register access
	input  wire logic                      timer_run_and_flags_wr,
	input  wire logic                      timer_mode_select_wr,
	input  wire logic [7:0]                sfr_wdata,
	input  wire logic [1:0]                cnt_wr,
	input  wire logic [15:0]               cnt_wdata,
	output      t01cm_pkg::t01cm_timer_run_and_flags_t    timer_run_and_flags_r,
	output      t01cm_pkg::t01cm_timer_mode_select_t    timer_mode_select_r,
	output      logic [1:0][15:0]          cnt_r,
	// Clock configuration
	input  wire logic [1:0]                clock_source_select,
	input  wire logic                      prescale_tick,
	// External pins
	input  wire logic [1:0]                timer_event_pin,
	input  wire logic [1:0]                ext_irq_pin_n,
	// Interrupt controller
	input  wire logic [1:0]                timer_irq_en,
	input  wire logic [1:0]                timer_ack,
	input  wire logic [1:0]                ext_ack,
	output      logic [1:0]                timer_irq_r
);
	import t01cm_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Pin history for edge detection

	logic [1:0] event_prev_r;
	logic [1:0] irq_prev_r;

	always_ff @(posedge clk) begin
		if (!nrst) begin
			event_prev_r <= 2'h0;
			irq_prev_r   <= 2'h3;
		end else begin
			event_prev_r <= timer_event_pin;
			irq_prev_r   <= ext_irq_pin_n;
		end
	end

	wire logic [1:0] event_fall = event_prev_r & ~timer_event_pin;
	wire logic [1:0] irq_fall   = irq_prev_r & ~ext_irq_pin_n;

	////////////////////////////////////////////////////////////////////////////////
	// Per-timer controls

	wire logic [1:0]      run_bit  = {timer_run_and_flags_r.tr1, timer_run_and_flags_r.tr0};
	wire logic [1:0]      gate_bit = {timer_mode_select_r.timer1_gate_control, timer_mode_select_r.timer0_gate_control};
	wire logic [1:0]      ct_bit   = {timer_mode_select_r.ct1, timer_mode_select_r.ct0};
	wire logic [1:0][1:0] mode_fld = {timer_mode_select_r.t1m, timer_mode_select_r.t0m};

	// Gate lets the pin measure a pulse width
	wire logic [1:0] enabled = run_bit & (~gate_bit | ext_irq_pin_n);
	wire logic [1:0] int_tick = clock_source_select | {2{prescale_tick}};
	wire logic [1:0] tick = (ct_bit & event_fall) | (~ct_bit & int_tick);

	logic [1:0]            inc;
	logic [1:0]            ovf;
	logic [1:0][15:0]      cnt_nxt;

	////////////////////////////////////////////////////////////////////////////////
	// Count registers

	for (genvar i = 0; i < 2; i++) begin : g_tmr
		wire logic        is13 = (mode_fld[i] == MODE_13B);
		wire logic        is16 = (mode_fld[i] == MODE_16B);
		wire logic [12:0] c13  = {cnt_r[i][15:8], cnt_r[i][TL_LO_W-1:0]};
		wire logic [12:0] c13n = c13 + CNT13_ONE;
		wire logic [15:0] c16n = cnt_r[i] + CNT16_ONE;

		// Modes 2 and 3 are outside this block and hold the count
		assign inc[i] = enabled[i] & tick[i] & (is13 | is16);
		assign ovf[i] = inc[i] & ((is13 & (c13 == CNT13_MAX)) |
			(is16 & (cnt_r[i] == CNT16_MAX)));

		// Upper bits of the low byte are left untouched in 13-bit mode
		assign cnt_nxt[i] = cnt_wr[i] ? cnt_wdata :
			!inc[i] ? cnt_r[i] :
			is13 ? {c13n[12:TL_LO_W], cnt_r[i][7:TL_LO_W], c13n[TL_LO_W-1:0]} :
			c16n;

		always_ff @(posedge clk) begin
			if (!nrst) begin
				cnt_r[i] <= CNT_RST;
			end else begin
				cnt_r[i] <= cnt_nxt[i];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Control register update

	wire t01cm_timer_run_and_flags_t timer_run_and_flags_wd = t01cm_timer_run_and_flags_t'(sfr_wdata);

	// Level mode keeps the flag set while the pin stays low
	wire logic [1:0] ext_set = {
		timer_run_and_flags_r.it1 ? irq_fall[1] : ~ext_irq_pin_n[1],
		timer_run_and_flags_r.it0 ? irq_fall[0] : ~ext_irq_pin_n[0]};

	t01cm_timer_run_and_flags_t timer_run_and_flags_nxt;

	// Hardware set wins over an ack or a software clear in the same cycle
	assign timer_run_and_flags_nxt.tf1 = ovf[1] | (timer_run_and_flags_wr ? timer_run_and_flags_wd.tf1 : timer_run_and_flags_r.tf1 & ~timer_ack[1]);
	assign timer_run_and_flags_nxt.tf0 = ovf[0] | (timer_run_and_flags_wr ? timer_run_and_flags_wd.tf0 : timer_run_and_flags_r.tf0 & ~timer_ack[0]);
	assign timer_run_and_flags_nxt.ie1 = ext_set[1] | (timer_run_and_flags_wr ? timer_run_and_flags_wd.ie1 : timer_run_and_flags_r.ie1 & ~ext_ack[1]);
	assign timer_run_and_flags_nxt.ie0 = ext_set[0] | (timer_run_and_flags_wr ? timer_run_and_flags_wd.ie0 : timer_run_and_flags_r.ie0 & ~ext_ack[0]);
	assign timer_run_and_flags_nxt.tr1 = timer_run_and_flags_wr ? timer_run_and_flags_wd.tr1 : timer_run_and_flags_r.tr1;
	assign timer_run_and_flags_nxt.tr0 = timer_run_and_flags_wr ? timer_run_and_flags_wd.tr0 : timer_run_and_flags_r.tr0;
	assign timer_run_and_flags_nxt.it1 = timer_run_and_flags_wr ? timer_run_and_flags_wd.it1 : timer_run_and_flags_r.it1;
	assign timer_run_and_flags_nxt.it0 = timer_run_and_flags_wr ? timer_run_and_flags_wd.it0 : timer_run_and_flags_r.it0;

	wire t01cm_timer_mode_select_t timer_mode_select_nxt = timer_mode_select_wr ? t01cm_timer_mode_select_t'(sfr_wdata) : timer_mode_select_r;

	always_ff @(posedge clk) begin
		if (!nrst) begin
			timer_run_and_flags_r      <= t01cm_timer_run_and_flags_t'(TIMER_RUN_AND_FLAGS_RST);
			timer_mode_select_r      <= t01cm_timer_mode_select_t'(TIMER_MODE_SELECT_RST);
			timer_irq_r <= 2'h0;
		end else begin
			timer_run_and_flags_r      <= timer_run_and_flags_nxt;
			timer_mode_select_r      <= timer_mode_select_nxt;
			timer_irq_r <= {timer_run_and_flags_r.tf1, timer_run_and_flags_r.tf0} & timer_irq_en;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Assertions

	property p_ovf_sets_flag;
		@(posedge clk) disable iff (!nrst)
		ovf[0] |=> timer_run_and_flags_r.tf0;
	endproperty
	a_ovf_sets_flag: assert property (p_ovf_sets_flag) else $error("overflow did not set flag");

	property p_irq_follows_flag;
		@(posedge clk) disable iff (!nrst)
		(timer_run_and_flags_r.tf1 && timer_irq_en[1]) |=> timer_irq_r[1];
	endproperty
	a_irq_follows_flag: assert property (p_irq_follows_flag) else $error("no timer 1 request");

	property p_stopped_holds;
		@(posedge clk) disable iff (!nrst)
		(!timer_run_and_flags_r.tr0 && !cnt_wr[0]) |=> $stable(cnt_r[0]);
	endproperty
	a_stopped_holds: assert property (p_stopped_holds) else $error("timer 0 counted while stopped");

	property p_gate_holds;
		@(posedge clk) disable iff (!nrst)
		(timer_mode_select_r.timer1_gate_control && !ext_irq_pin_n[1] && !cnt_wr[1]) |=> $stable(cnt_r[1]);
	endproperty
	a_gate_holds: assert property (p_gate_holds) else $error("timer 1 counted while gated off");

	property p_event_counts;
		@(posedge clk) disable iff (!nrst)
		(timer_mode_select_r.ct1 && timer_run_and_flags_r.tr1 && !timer_mode_select_r.timer1_gate_control && timer_mode_select_r.t1m == MODE_16B
			&& event_fall[1] && !cnt_wr[1]) |=> cnt_r[1] == $past(cnt_r[1]) + CNT16_ONE;
	endproperty
	a_event_counts: assert property (p_event_counts) else $error("pin edge not counted");

	property p_internal_counts;
		@(posedge clk) disable iff (!nrst)
		(!timer_mode_select_r.ct1 && clock_source_select[1] && timer_run_and_flags_r.tr1 && !timer_mode_select_r.timer1_gate_control
			&& timer_mode_select_r.t1m == MODE_16B && !cnt_wr[1]) |=> cnt_r[1] == $past(cnt_r[1]) + CNT16_ONE;
	endproperty
	a_internal_counts: assert property (p_internal_counts) else $error("system clock not counted");

	property p_wrap13;
		@(posedge clk) disable iff (!nrst)
		(inc[1] && timer_mode_select_r.t1m == MODE_13B && cnt_r[1][15:8] == 8'hFF
			&& cnt_r[1][4:0] == 5'h1F && !cnt_wr[1]) |=> (cnt_r[1][15:8] == 8'h00
			&& cnt_r[1][4:0] == 5'h00 && timer_run_and_flags_r.tf1);
	endproperty
	a_wrap13: assert property (p_wrap13) else $error("13-bit wrap wrong");

	property p_mode_write;
		@(posedge clk) disable iff (!nrst)
		timer_mode_select_wr |=> timer_mode_select_r == $past(sfr_wdata);
	endproperty
	a_mode_write: assert property (p_mode_write) else $error("mode register not written");

	property p_ack_clears;
		@(posedge clk) disable iff (!nrst)
		(ext_ack[0] && !ext_set[0] && !timer_run_and_flags_wr) |=> !timer_run_and_flags_r.ie0;
	endproperty
	a_ack_clears: assert property (p_ack_clears) else $error("ack did not clear pending");

	property p_level_sets;
		@(posedge clk) disable iff (!nrst)
		(!timer_run_and_flags_r.it0 && !ext_irq_pin_n[0]) |=> timer_run_and_flags_r.ie0;
	endproperty
	a_level_sets: assert property (p_level_sets) else $error("low level did not set pending");

	property p_edge_sets;
		@(posedge clk) disable iff (!nrst)
		(timer_run_and_flags_r.it1 && irq_prev_r[1] && !ext_irq_pin_n[1]) |=> timer_run_and_flags_r.ie1;
	endproperty
	a_edge_sets: assert property (p_edge_sets) else $error("falling edge did not set pending");

	// Modes 2 and 3 belong to a neighbour, so the count must not move here
	property p_mode_hold;
		@(posedge clk) disable iff (!nrst)
		(timer_mode_select_r.t1m != MODE_13B && timer_mode_select_r.t1m != MODE_16B && !cnt_wr[1]) |=> $stable(cnt_r[1]);
	endproperty
	a_mode_hold: assert property (p_mode_hold) else $error("timer 1 counted in mode 2 or 3");

	property p_soft_clears;
		@(posedge clk) disable iff (!nrst)
		(timer_run_and_flags_wr && !timer_run_and_flags_wd.ie0 && !ext_set[0]) |=> !timer_run_and_flags_r.ie0;
	endproperty
	a_soft_clears: assert property (p_soft_clears) else $error("software did not clear pending");

endmodule

//--- sim/test_timer01_control_mode_regs.sv
// Self-checking bench for the timer 0/1 control and mode registers
`timescale 1ns/1ns

module test_timer01_control_mode_regs;
	import t01cm_pkg::*;
	////////////////////////////////////////////////////////////////
	logic              clk, nrst, timer_run_and_flags_wr, timer_mode_select_wr, prescale_tick;
	logic [7:0]        sfr_wdata, rnd;
	logic [1:0]        cnt_wr, css, ev_pin, irq_pin_n;
	logic [1:0]        irq_en, t_ack, e_ack, timer_irq_r;
	logic [15:0]       cnt_wdata;
	logic [1:0][15:0]  cnt_r;
	t01cm_timer_run_and_flags_t       timer_run_and_flags_r;
	t01cm_timer_mode_select_t       timer_mode_select_r;
	int                fails, checks_done;
	logic [2:0]        sel_q[$];
	logic [15:0]       exp_q[$];

	t01cm_timer_regs u_dut (.clk(clk), .nrst(nrst), .timer_run_and_flags_wr(timer_run_and_flags_wr), .timer_mode_select_wr(timer_mode_select_wr),
		.sfr_wdata(sfr_wdata), .cnt_wr(cnt_wr), .cnt_wdata(cnt_wdata), .timer_run_and_flags_r(timer_run_and_flags_r),
		.timer_mode_select_r(timer_mode_select_r), .cnt_r(cnt_r), .clock_source_select(css),
		.prescale_tick(prescale_tick), .timer_event_pin(ev_pin), .ext_irq_pin_n(irq_pin_n),
		.timer_irq_en(irq_en), .timer_ack(t_ack), .ext_ack(e_ack), .timer_irq_r(timer_irq_r));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////
	task automatic note(input logic [2:0] s, input logic [15:0] e);
		sel_q.push_back(s);
		exp_q.push_back(e);
	endtask
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] e);
		checks_done++;
		if (seen !== e) begin
			fails++;
			$display("unexpected %s expected %h seen %h", what, e, seen);
		end
	endtask
	// One strobed cycle, entered and left at a falling edge
	task automatic cyc(input logic tc, input logic tm, input logic [1:0] cw,
		input logic [7:0] d, input logic [15:0] cv);
		timer_run_and_flags_wr = tc;
		timer_mode_select_wr = tm;
		cnt_wr = cw;
		sfr_wdata = d;
		cnt_wdata = cv;
		@(negedge clk);
		timer_run_and_flags_wr = 1'b0;
		timer_mode_select_wr = 1'b0;
		cnt_wr = 2'h0;
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	// Watcher: outputs only move at rising edges, so notes are judged at once
	initial begin
		logic [2:0] s;
		logic [15:0] e;
		forever begin
			wait (sel_q.size() != 0);
			s = sel_q.pop_front();
			e = exp_q.pop_front();
			case (s)
				3'h0: check("timer_run_and_flags", {8'h00, timer_run_and_flags_r}, e);
				3'h1: check("timer_mode_select", {8'h00, timer_mode_select_r}, e);
				3'h2: check("cnt0", cnt_r[0], e);
				3'h3: check("cnt1", cnt_r[1], e);
				default: check("irq", {14'h0000, timer_irq_r}, e);
			endcase
		end
	end
	initial begin
		repeat (3000) @(posedge clk);
		fails++;
		tally_and_finish();
	end
	////////////////////////////////////////////////////////////////
	initial begin
		{nrst, timer_run_and_flags_wr, timer_mode_select_wr, prescale_tick, sfr_wdata, cnt_wr, cnt_wdata} = '0;
		{css, ev_pin, irq_en, t_ack, e_ack} = '0;
		irq_pin_n = 2'h3;
		void'($urandom(31));
		repeat (10) @(negedge clk);
		nrst = 1'b1;
		for (int i = 0; i < 5; i++) note(3'(i), 16'h0000);
		@(negedge clk);
		rnd = 8'($urandom);
		cyc(1'b0, 1'b1, 2'h0, rnd, 16'h0000);
		note(3'h1, {8'h00, rnd});
		// Idle edge between writes, so no strobe is driven twice in one step
		@(negedge clk);
		// Both timers wrap: timer 0 in 16-bit mode, timer 1 in 13-bit mode
		cyc(1'b0, 1'b1, 2'h3, 8'h01, 16'hFFFF);
		@(negedge clk);
		irq_en = 2'h3;
		css = 2'h3;
		cyc(1'b1, 1'b0, 2'h0, 8'h50, 16'h0000);
		@(negedge clk);
		css = 2'h0;
		note(3'h2, 16'h0000);
		note(3'h3, 16'h00E0);
		note(3'h0, 16'h00F0);
		@(negedge clk);
		note(3'h4, 16'h0003);
		t_ack = 2'h3;
		@(negedge clk);
		t_ack = 2'h0;
		@(negedge clk);
		note(3'h0, 16'h0050);
		note(3'h4, 16'h0000);
		// Gate blocks counting while the interrupt pin is low
		irq_pin_n = 2'h1;
		cyc(1'b0, 1'b1, 2'h2, 8'h90, 16'h0000);
		css = 2'h2;
		repeat (4) @(negedge clk);
		irq_pin_n = 2'h3;
		repeat (3) @(negedge clk);
		css = 2'h0;
		@(negedge clk);
		note(3'h3, 16'h0003);
		// Prescaled tick is the only source when the select is low
		cyc(1'b0, 1'b1, 2'h2, 8'h10, 16'h0000);
		repeat (3) begin
			prescale_tick = 1'b1;
			@(negedge clk);
			prescale_tick = 1'b0;
			@(negedge clk);
		end
		note(3'h3, 16'h0003);
		// Counter mode ignores the fast clock select
		cyc(1'b0, 1'b1, 2'h2, 8'h50, 16'h0000);
		css = 2'h2;
		repeat (4) begin
			ev_pin = 2'h2;
			repeat (2) @(negedge clk);
			ev_pin = 2'h0;
			repeat (2) @(negedge clk);
		end
		css = 2'h0;
		note(3'h3, 16'h0004);
		// Mode 2 is handled elsewhere, so the count must hold
		cyc(1'b0, 1'b1, 2'h2, 8'h20, 16'h0005);
		css = 2'h2;
		repeat (3) @(negedge clk);
		css = 2'h0;
		note(3'h3, 16'h0005);
		// External interrupt 0: edge mode, acknowledge, then level mode
		cyc(1'b1, 1'b0, 2'h0, 8'h41, 16'h0000);
		irq_pin_n = 2'h2;
		@(negedge clk);
		note(3'h0, 16'h0043);
		e_ack = 2'h1;
		@(negedge clk);
		e_ack = 2'h0;
		@(negedge clk);
		note(3'h0, 16'h0041);
		cyc(1'b1, 1'b0, 2'h0, 8'h40, 16'h0000);
		// Level mode only takes effect one edge after the write
		@(negedge clk);
		note(3'h0, 16'h0042);
		irq_pin_n = 2'h3;
		cyc(1'b1, 1'b0, 2'h0, 8'h40, 16'h0000);
		note(3'h0, 16'h0040);
		@(negedge clk);
		tally_and_finish();
	end
endmodule
